// *** verilog/sync_meas_defines.vh ***
/*
 * Constants for the sync frame measurement table: register offsets,
 * field positions, reset values and table sizes.
 * Assumes inclusion by bare name from the design files of this block.
 */
`ifndef SYNC_MEAS_DEFINES_VH
`define SYNC_MEAS_DEFINES_VH

// ************************************************************
// register offsets (byte addresses, 16-bit registers)
// ************************************************************
`define OFS_CTRL            10'h330
`define OFS_EVEN_COUNT      10'h33c
`define OFS_ODD_COUNT       10'h33e
`define OFS_EVEN_A          10'h340
`define OFS_EVEN_B          10'h360
`define OFS_EVEN_ID         10'h380
`define OFS_ODD_A           10'h3a0
`define OFS_ODD_B           10'h3c0
`define OFS_ODD_ID          10'h3e0

// table block select is address bits 9:5, entry index is bits 4:1
`define BLK_HI              9
`define BLK_LO              5
`define IDX_HI              4
`define IDX_LO              1

// ************************************************************
// fields and reset values
// ************************************************************
`define CTRL_FILTER_EN      0
`define CTRL_SYNC_NODE      1
`define CTRL_RESET          2'h0
`define COUNT_W             4
`define COUNT_FULL          5'h10
`define COUNT_SAT           4'hf
`define COUNT_CLR_NONSYNC   5'h00
`define COUNT_CLR_SYNC      5'h01
`define ID_W                11
`define MEAS_W              16
`define NORM_CONST          16'h0004
`define TABLE_DEPTH         16

`endif

// *** verilog/reset_sync2.v ***
/*
 * Two-stage reset release synchroniser.
 * Assumes an asynchronous active-low reset input and one clock.
 */
module reset_sync2
(
    input  wire clk,
    input  wire arst_n,
    output wire srst_n
);

    reg stage1_q;
    reg stage2_q;

    // ************************************************************
    // assert at once, release after two edges
    // ************************************************************
    always @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            stage1_q <= 1'b0;
            stage2_q <= 1'b0;
        end
        else
        begin
            stage1_q <= 1'b1;
            stage2_q <= stage1_q;
        end
    end

    assign srst_n = stage2_q;

endmodule // reset_sync2

// *** verilog/meas_entry_ram.v ***
/*
 * Measurement entry store for one cycle parity: sync frame id,
 * channel A and channel B arrival time per entry.
 * Assumes one write per cycle; content is undefined until written.
 */
module meas_entry_ram
#(
    parameter DEPTH = 16,
    parameter IW    = 4,
    parameter W     = 43
)
(
    input  wire          clk,
    input  wire          wr_en,
    input  wire [IW-1:0] wr_idx,
    input  wire [W-1:0]  wr_data,
    input  wire [IW-1:0] rd_idx,
    output wire [W-1:0]  rd_data
);

    reg [W-1:0] mem [0:DEPTH-1];

    // ************************************************************
    // write port, no reset: entries past the count are don't-care
    // ************************************************************
    always @(posedge clk)
    begin
        if (wr_en)
            mem[wr_idx] <= wr_data;
    end

    // combinational read, registered by the bus slave
    assign rd_data = mem[rd_idx];

endmodule // meas_entry_ram

// *** verilog/sync_meas_table.v ***
/*
 * Sync frame measurement table: per parity and channel arrival times,
 * sync frame id lists and valid-entry counters, read by the host.
 * Assumes all non-bus inputs come from controller logic on CLK,
 * that at most one sync slot result arrives per cycle, that clear
 * events are one-cycle pulses, and that the configuration inputs
 * stay steady while the static segment is being measured.
 */
//
// Function
// R1 - entry holds 16-bit microtick arrival time
// R2 - sixteen odd channel B entries at 0x3c0
// R3 - sixteen even channel A entries at 0x340
// R4 - sixteen even channel B entries at 0x360
// R5 - host subtracts reference offset for deviation
// R6 - normalise times to larger delay compensation
// R7 - zero marks an invalid channel entry
// R8 - two 4-bit counters, upper bits reserved
// R9 - filtering on: only passing sync frames count
// R10 - count gives number of valid leading entries; a full table of sixteen reads as fifteen
// R11 - increment once per slot with sync frame
// R12 - clear both on schedule init, collision resolution
// R13 - normal states: even cleared odd NIT, odd cycle-end
// R14 - clear value zero non-sync, one sync node
// R15 - sixteen odd channel A entries at 0x3a0
// R16 - sync node writes own id first entry
// R17 - sync node preloads first entries zero deviation
// R18 - write at count, then increment; stop at sixteen
`include "sync_meas_defines.vh"

module sync_meas_table
(
    input  wire        CLK,
    input  wire        RESETN,
    // register port
    input  wire [9:0]  ADDR,
    input  wire [15:0] WDATA,
    input  wire        WR,
    input  wire        RD,
    output wire [15:0] RDATA,
    // receive path: one pulse per static slot carrying a sync frame
    input  wire        SYNC_SLOT_DONE,
    input  wire        STATIC_SEGMENT,
    input  wire [10:0] SLOT_ID,
    input  wire        VALID_A,
    input  wire        VALID_B,
    input  wire [15:0] ARRIVAL_A,
    input  wire [15:0] ARRIVAL_B,
    input  wire        FILTER_PASS,
    // protocol state and cycle timing
    input  wire        CYCLE_ODD,
    input  wire        ENTER_INIT_SCHEDULE,
    input  wire        ENTER_COLLISION_RES,
    input  wire        NORMAL_STATE,
    input  wire        NIT_START,
    input  wire        CYCLE_END,
    // configuration from the controller
    input  wire [10:0] OWN_SYNC_ID,
    input  wire [15:0] NOMINAL_MACROTICK_LENGTH,
    input  wire [15:0] STATIC_ACTION_POINT_OFFSET,
    input  wire [15:0] START_SEQUENCE_LENGTH,
    input  wire [15:0] BIT_DURATION,
    input  wire [15:0] DELAY_COMP_CHAN_A,
    input  wire [15:0] DELAY_COMP_CHAN_B
);

    // entry index width and packed entry width: id, channel B, channel A
    localparam IW = 4;
    localparam EW = `ID_W + 2 * `MEAS_W;

    // table bases; bits 9:5 of each select its block in the read decode
    localparam [9:0] base_even_a  = `OFS_EVEN_A;
    localparam [9:0] base_even_b  = `OFS_EVEN_B;
    localparam [9:0] base_even_id = `OFS_EVEN_ID;
    localparam [9:0] base_odd_a   = `OFS_ODD_A;
    localparam [9:0] base_odd_b   = `OFS_ODD_B;
    localparam [9:0] base_odd_id  = `OFS_ODD_ID;

    // synchronous copy of the reset
    wire        rst_n;
    // registered state and next values
    reg  [1:0]  ctrl_q;
    reg  [4:0]  even_cnt_q;
    reg  [4:0]  even_cnt_d;
    reg  [4:0]  odd_cnt_q;
    reg  [4:0]  odd_cnt_d;
    reg  [15:0] rdata_q;
    reg  [15:0] rdata_d;

    // ************************************************************
    // reset release
    // ************************************************************
    reset_sync2 u_rst
    (
        .clk    (CLK),
        .arst_n (RESETN),
        .srst_n (rst_n)
    );

    // ************************************************************
    // normalisation and zero-deviation preload
    // ************************************************************
    wire        filter_en = ctrl_q[`CTRL_FILTER_EN];
    wire        sync_node = ctrl_q[`CTRL_SYNC_NODE];
    wire [15:0] dc_max    = (DELAY_COMP_CHAN_A > DELAY_COMP_CHAN_B) ?
                            DELAY_COMP_CHAN_A : DELAY_COMP_CHAN_B;
    wire [31:0] ap_prod   = NOMINAL_MACROTICK_LENGTH * STATIC_ACTION_POINT_OFFSET;
    wire [31:0] ss_prod   = START_SEQUENCE_LENGTH * BIT_DURATION;
    // arrival time of a frame lying exactly on the reference point;
    // sums wrap at 16 bits, matching the host's own register arithmetic
    wire [15:0] preload   = ap_prod[15:0] + ss_prod[15:0] + dc_max + `NORM_CONST; // R17 R5

    // channel pairs, channel A in the low half
    wire [31:0] arrival_pair = {ARRIVAL_B, ARRIVAL_A};
    wire [31:0] comp_pair    = {DELAY_COMP_CHAN_B, DELAY_COMP_CHAN_A};
    wire [1:0]  valid_pair   = {VALID_B, VALID_A};
    wire [31:0] meas_pair;

    // shift each channel onto the larger compensation so times stay positive;
    // the table holds no channel mark, so both must share one reference
    genvar ch;
    generate
        for (ch = 0; ch < 2; ch = ch + 1)
        begin : g_chan
            wire [15:0] comp_gap = dc_max - comp_pair[16*ch +: 16];
            wire [15:0] norm     = arrival_pair[16*ch +: 16] + comp_gap; // R6
            // zero marks a channel without a valid sync frame
            assign meas_pair[16*ch +: 16] = valid_pair[ch] ? norm : 16'h0000; // R7 R1
        end
    endgenerate

    wire [15:0] meas_a = meas_pair[15:0];
    wire [15:0] meas_b = meas_pair[31:16];

    // ************************************************************
    // events: clears and accepted sync frames
    // ************************************************************
    // clears come from protocol state entries and fixed points of the cycle
    wire state_clr = ENTER_INIT_SCHEDULE | ENTER_COLLISION_RES; // R12
    wire even_clr  = state_clr | (NORMAL_STATE & NIT_START & CYCLE_ODD); // R13
    wire odd_clr   = state_clr | (NORMAL_STATE & CYCLE_END & ~CYCLE_ODD); // R13
    // frames outside the static segment or refused by the filters are dropped
    wire frame_ok  = SYNC_SLOT_DONE & STATIC_SEGMENT & (VALID_A | VALID_B) &
                     (~filter_en | FILTER_PASS); // R11 R9
    wire even_hit  = frame_ok & ~CYCLE_ODD & (even_cnt_q != `COUNT_FULL); // R18
    wire odd_hit   = frame_ok &  CYCLE_ODD & (odd_cnt_q != `COUNT_FULL); // R18
    wire [4:0] clr_val = sync_node ? `COUNT_CLR_SYNC : `COUNT_CLR_NONSYNC; // R14

    // entry contents: frame measurement or own zero-deviation entry
    wire [EW-1:0] frame_entry = {SLOT_ID, meas_b, meas_a};
    wire [EW-1:0] own_entry   = {OWN_SYNC_ID, preload, preload}; // R16 R17

    // ************************************************************
    // counter next values; a clear beats a frame in the same cycle
    // ************************************************************
    // even parity: clear value, else one more per accepted slot
    always @*
    begin
        even_cnt_d = even_cnt_q;
        if (even_clr)
            even_cnt_d = clr_val; // R12 R13 R14
        else if (even_hit)
            even_cnt_d = even_cnt_q + 5'h01; // R11 R18
    end

    // odd parity: same scheme, its own clear points
    always @*
    begin
        odd_cnt_d = odd_cnt_q;
        if (odd_clr)
            odd_cnt_d = clr_val; // R12 R13 R14
        else if (odd_hit)
            odd_cnt_d = odd_cnt_q + 5'h01; // R11 R18
    end

    // ************************************************************
    // counters and control register
    // ************************************************************
    // counters: five bits so a full table of sixteen differs from fifteen
    always @(posedge CLK or negedge rst_n)
    begin
        if (!rst_n)
        begin
            even_cnt_q <= `COUNT_CLR_NONSYNC;
            odd_cnt_q  <= `COUNT_CLR_NONSYNC;
        end
        else
        begin
            even_cnt_q <= even_cnt_d;
            odd_cnt_q  <= odd_cnt_d;
        end
    end

    // control register: filter enable and sync node; the only writable word
    always @(posedge CLK or negedge rst_n)
    begin
        if (!rst_n)
            ctrl_q <= `CTRL_RESET;
        else if (WR && ADDR == `OFS_CTRL)
            ctrl_q <= WDATA[1:0];
    end

    // ************************************************************
    // table writes: own entry at 0 on clear of a sync node, else frame at count
    // ************************************************************
    // a sync node restarts each table with its own zero-deviation entry;
    // a non-sync node leaves stale entries, which the count marks unused
    wire          even_we   = (even_clr & sync_node) | (~even_clr & even_hit);
    wire          odd_we    = (odd_clr & sync_node) | (~odd_clr & odd_hit);
    wire [IW-1:0] even_widx = even_clr ? {IW{1'b0}} : even_cnt_q[IW-1:0]; // R18 R16
    wire [IW-1:0] odd_widx  = odd_clr ? {IW{1'b0}} : odd_cnt_q[IW-1:0]; // R18 R16
    wire [EW-1:0] even_wdat = even_clr ? own_entry : frame_entry;
    wire [EW-1:0] odd_wdat  = odd_clr ? own_entry : frame_entry;
    wire [IW-1:0] rd_idx    = ADDR[`IDX_HI:`IDX_LO];
    wire [EW-1:0] even_rd;
    wire [EW-1:0] odd_rd;

    // even parity tables: channel A, channel B, id list
    meas_entry_ram
    #(
        .DEPTH (`TABLE_DEPTH),
        .IW    (IW),
        .W     (EW)
    )
    u_even // R3 R4
    (
        .clk     (CLK),
        .wr_en   (even_we),
        .wr_idx  (even_widx),
        .wr_data (even_wdat),
        .rd_idx  (rd_idx),
        .rd_data (even_rd)
    );

    // odd parity tables: channel A, channel B, id list
    meas_entry_ram
    #(
        .DEPTH (`TABLE_DEPTH),
        .IW    (IW),
        .W     (EW)
    )
    u_odd // R2 R15
    (
        .clk     (CLK),
        .wr_en   (odd_we),
        .wr_idx  (odd_widx),
        .wr_data (odd_wdat),
        .rd_idx  (rd_idx),
        .rd_data (odd_rd)
    );

    // ************************************************************
    // read decode; counters show 4 bits, a full count of sixteen shown as fifteen
    // ************************************************************
    wire [4:0] blk = ADDR[`BLK_HI:`BLK_LO];
    wire [3:0] even_show = (even_cnt_q == `COUNT_FULL) ? `COUNT_SAT : even_cnt_q[3:0]; // R8 R10
    wire [3:0] odd_show  = (odd_cnt_q == `COUNT_FULL) ? `COUNT_SAT : odd_cnt_q[3:0]; // R8 R10

    // address decode for reads; idle cycles and holes read zero, and
    // entries past the count show stale data the host must ignore
    always @*
    begin
        rdata_d = 16'h0000;
        if (!RD)
            rdata_d = 16'h0000;
        else if (ADDR == `OFS_CTRL)
            rdata_d = {14'h0000, ctrl_q};
        else if (ADDR == `OFS_EVEN_COUNT)
            rdata_d = {12'h000, even_show}; // R8
        else if (ADDR == `OFS_ODD_COUNT)
            rdata_d = {12'h000, odd_show}; // R8
        else if (ADDR[0])
            rdata_d = 16'h0000;
        // table blocks: A in bits 15:0, B in 31:16, id in 42:32 of an entry
        else if (blk == base_even_a[`BLK_HI:`BLK_LO])
            rdata_d = even_rd[15:0]; // R3
        else if (blk == base_even_b[`BLK_HI:`BLK_LO])
            rdata_d = even_rd[31:16]; // R4
        else if (blk == base_even_id[`BLK_HI:`BLK_LO])
            rdata_d = {5'h00, even_rd[42:32]};
        else if (blk == base_odd_a[`BLK_HI:`BLK_LO])
            rdata_d = odd_rd[15:0]; // R15
        else if (blk == base_odd_b[`BLK_HI:`BLK_LO])
            rdata_d = odd_rd[31:16]; // R2
        else if (blk == base_odd_id[`BLK_HI:`BLK_LO])
            rdata_d = {5'h00, odd_rd[42:32]};
        else
            rdata_d = 16'h0000;
    end

    // read data valid only in the cycle after the strobe
    always @(posedge CLK or negedge rst_n)
    begin
        if (!rst_n)
            rdata_q <= 16'h0000;
        else
            rdata_q <= rdata_d;
    end

    // bus read data straight from the register
    assign RDATA = rdata_q;

endmodule // sync_meas_table

// *** testbench/sync_meas_table_asserts.sv ***
/* port assertions for the sync measurement table
   assumes a bind onto sync_meas_table */
module sync_meas_chk
(
    input logic        CLK,
    input logic        RESETN,
    input logic [9:0]  ADDR,
    input logic        RD,
    input logic [15:0] RDATA,
    input logic        ENTER_INIT_SCHEDULE,
    input logic        ENTER_COLLISION_RES,
    input logic        NORMAL_STATE,
    input logic        NIT_START,
    input logic        CYCLE_END,
    input logic        CYCLE_ODD
);
    timeunit 1ns;
    timeprecision 1ps;
    // ****
    // read port and counter clears
    // ****
    default clocking dc @(posedge CLK); endclocking
    default disable iff (!RESETN);
    sequence s_rd_even; RD && ADDR == 10'h33c; endsequence
    sequence s_rd_odd; RD && ADDR == 10'h33e; endsequence
    AST_IDLE: assert property (!RD |=> RDATA == 16'h0000)
        else $error("read data not idle");
    AST_CNT_HI: assert property (RD && ADDR[9:2] == 8'hcf && !ADDR[0] |=> RDATA[15:4] == 12'h000)
        else $error("count upper bits set");
    AST_ODD_ADR: assert property (RD && ADDR[0] |=> RDATA == 16'h0000)
        else $error("odd address read nonzero");
    AST_ID_HI: assert property (RD && (ADDR[9:5] == 5'h1c || ADDR[9:5] == 5'h1f) |=> RDATA[15:11] == 5'h00)
        else $error("id upper bits set");
    AST_INIT: assert property (ENTER_INIT_SCHEDULE ##1 s_rd_even |=> RDATA[3:0] <= 4'h1)
        else $error("even count not cleared on init");
    AST_COLL: assert property (ENTER_COLLISION_RES ##1 s_rd_odd |=> RDATA[3:0] <= 4'h1)
        else $error("odd count not cleared on collision");
    AST_NIT: assert property (NORMAL_STATE && NIT_START && CYCLE_ODD ##1 s_rd_even |=> RDATA[3:0] <= 4'h1)
        else $error("even count not cleared in idle time");
    AST_END: assert property (NORMAL_STATE && CYCLE_END && !CYCLE_ODD ##1 s_rd_odd |=> RDATA[3:0] <= 4'h1)
        else $error("odd count not cleared at cycle end");
endmodule // sync_meas_chk
bind sync_meas_table sync_meas_chk u_chk (.CLK, .RESETN, .ADDR, .RD, .RDATA, .ENTER_INIT_SCHEDULE,
    .ENTER_COLLISION_RES, .NORMAL_STATE, .NIT_START, .CYCLE_END, .CYCLE_ODD);

// *** testbench/sync_rx_model.sv ***
/* receive path model: one pulse per static slot
   assumes the bench calls send from its main thread */
module sync_rx_model
(
    input  logic        clk,
    output logic        done = 1'b0,
    output logic        st = 1'b0,
    output logic        va = 1'b0,
    output logic        vb = 1'b0,
    output logic        pass = 1'b0,
    output logic [10:0] id = 11'h000,
    output logic [15:0] ta = 16'h0000,
    output logic [15:0] tb = 16'h0000
);
    timeunit 1ns;
    timeprecision 1ps;
    // ****
    // slot delivery, prompt or after a gap
    // ****
    task automatic send(input int gap, input logic s, a, b, p, input logic [10:0] i, input logic [15:0] x, y);
        repeat (gap) @(posedge clk);
        @(posedge clk);
        done <= 1'b1;
        st <= s;
        va <= a;
        vb <= b;
        pass <= p;
        id <= i;
        ta <= x;
        tb <= y;
        @(posedge clk);
        done <= 1'b0; // single pulse per slot
        va <= 1'b0;
        vb <= 1'b0;
        ta <= ~x; // released lines hold garbage
        tb <= ~y;
    endtask
endmodule // sync_rx_model

// *** testbench/sync_meas_table_tb_top.sv ***
/* random self-checking bench for the sync measurement table
   assumes the checker and the receive model compiled before it */
module sync_meas_table_tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    logic        clk, rst_n = 1'b0, wr_s = 1'b0, rd_s = 1'b0, odd = 1'b0, norm = 1'b0;
    logic        done, st, va, vb, pass;
    logic [9:0]  addr = 10'h000;
    logic [15:0] wdata = 16'h0000, rdata, nml, sap, tss, bit_duration, dca, dcb, ta, tb, v;
    logic [10:0] own, sid;
    logic [3:0]  ev = 4'h0;
    logic [1:0]  ctrl = 2'h0;
    logic [31:0] seed = 32'hc603, r;
    logic [15:0] ea[2][16], eb[2][16];
    logic [10:0] ei[2][16];
    int          cnt[2] = '{0, 0};
    int          mismatches = 0, cmp_count = 0;

    sync_meas_table DUT
    (
        .CLK(clk), .RESETN(rst_n), .ADDR(addr), .WDATA(wdata), .WR(wr_s), .RD(rd_s), .RDATA(rdata),
        .SYNC_SLOT_DONE(done), .STATIC_SEGMENT(st), .SLOT_ID(sid), .VALID_A(va), .VALID_B(vb),
        .ARRIVAL_A(ta), .ARRIVAL_B(tb), .FILTER_PASS(pass), .CYCLE_ODD(odd),
        .ENTER_INIT_SCHEDULE(ev[0]), .ENTER_COLLISION_RES(ev[1]), .NORMAL_STATE(norm),
        .NIT_START(ev[2]), .CYCLE_END(ev[3]), .OWN_SYNC_ID(own), .NOMINAL_MACROTICK_LENGTH(nml),
        .STATIC_ACTION_POINT_OFFSET(sap), .START_SEQUENCE_LENGTH(tss), .BIT_DURATION(bit_duration),
        .DELAY_COMP_CHAN_A(dca), .DELAY_COMP_CHAN_B(dcb)
    );
    sync_rx_model rx
    (
        .clk(clk), .done(done), .st(st), .va(va), .vb(vb), .pass(pass), .id(sid), .ta(ta), .tb(tb)
    );

    // ****
    // helpers and reference model
    // ****
    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction
    function automatic logic [15:0] mx();
        return (dca > dcb) ? dca : dcb;
    endfunction
    function automatic logic [15:0] shown(input int c);
        return (c > 15) ? 16'h000f : 16'(c); // four-bit field saturates
    endfunction
    function automatic logic [15:0] pre();
        return nml * sap + tss * bit_duration + mx() + 16'h0004;
    endfunction
    task automatic cmp(input string n, input logic [15:0] e, g);
        cmp_count++;
        if (g !== e)
        begin
            mismatches++;
            $display("mismatch %s expected %h seen %h", n, e, g);
        end
    endtask
    task automatic reg_wr(input logic [9:0] a, input logic [15:0] d);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        wr_s <= 1'b1;
        @(posedge clk);
        wr_s <= 1'b0;
    endtask
    task automatic reg_rd(input logic [9:0] a, output logic [15:0] q);
        @(posedge clk);
        addr <= a;
        rd_s <= 1'b1;
        ev <= 4'h0; // ends any clear pulse
        @(posedge clk);
        rd_s <= 1'b0;
        @(negedge clk);
        q = rdata;
    endtask
    task automatic clr(input int p);
        cnt[p] = ctrl[1];
        if (ctrl[1])
        begin
            ea[p][0] = pre();
            eb[p][0] = pre();
            ei[p][0] = own;
        end
    endtask
    task automatic pulse(input int i);
        @(posedge clk);
        ev <= 4'h1 << i;
        reg_rd((i % 2 == 1) ? 10'h33e : 10'h33c, v);
        if (i < 2)
        begin
            clr(0);
            clr(1);
        end
        else if (norm && odd == (i == 2))
            clr(i - 2);
        cmp("count", shown(cnt[i % 2]), v);
    endtask
    task automatic frame();
        logic [31:0] q;
        logic [15:0] x, y;
        int p;
        q = rnd();
        x = 16'(rnd());
        y = 16'(rnd());
        rx.send(int'(q[3:2]), q[0] | q[1], q[4], q[5], q[6], q[17:7], x, y);
        p = odd;
        if ((q[0] | q[1]) && (q[4] | q[5]) && (!ctrl[0] || q[6]) && cnt[p] < 16)
        begin
            ea[p][cnt[p]] = q[4] ? x + mx() - dca : 16'h0000;
            eb[p][cnt[p]] = q[5] ? y + mx() - dcb : 16'h0000;
            ei[p][cnt[p]] = q[17:7];
            cnt[p]++;
        end
    endtask
    task automatic chk();
        for (int p = 0; p < 2; p++)
        begin
            reg_rd(10'(10'h33c + 2 * p), v);
            cmp("count", shown(cnt[p]), v);
            for (int i = 0; i < cnt[p] && i < 16; i++)
            begin
                reg_rd(10'(10'h340 + 96 * p + 2 * i), v);
                cmp("chan_a", ea[p][i], v);
                reg_rd(10'(10'h360 + 96 * p + 2 * i), v);
                cmp("chan_b", eb[p][i], v);
                reg_rd(10'(10'h380 + 96 * p + 2 * i), v);
                cmp("sync_id", {5'h00, ei[p][i]}, v);
            end
        end
    endtask
    task automatic print_verdict();
        $display("comparisons %0d mismatches %0d", cmp_count, mismatches);
        if (mismatches == 0 && cmp_count > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask

    // ****
    // clock, watchdog and main sequence
    // ****
    initial
    begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end
    initial
    begin
        repeat (100000) @(posedge clk);
        mismatches++;
        print_verdict();
    end
    initial
    begin
        {nml, sap, tss, bit_duration} = {rnd(), rnd()};
        {dca, dcb} = rnd();
        own = 11'(rnd());
        repeat (20) @(posedge clk);
        rst_n <= 1'b1;
        repeat (3) @(posedge clk);
        reg_rd(10'h33c, v);
        cmp("count", 16'h0000, v);
        reg_rd(10'h000, v);
        cmp("unmapped", 16'h0000, v);
        reg_rd(10'h341, v);
        cmp("odd_addr", 16'h0000, v);
        for (int k = 0; k < 400; k++)
        begin
            r = rnd();
            if (k % 50 == 49)
            begin
                ctrl = r[21:20];
                reg_wr(10'h330, {14'h0000, ctrl});
                reg_rd(10'h330, v);
                cmp("ctrl", {14'h0000, ctrl}, v);
                reg_wr(10'h340, r[15:0]);
            end
            @(posedge clk);
            odd <= (k > 40) ? r[8] : 1'b0;
            norm <= r[9];
            if (r[12:10] == 3'h0 && k > 40)
                pulse(int'(r[14:13]));
            else
                frame();
            if (k % 25 == 24)
                chk();
        end
        chk();
        print_verdict();
    end
endmodule // sync_meas_table_tb_top
